/* File: common/ssq_pkg.sv */
package ssq_pkg;

  // Register byte offsets on the APB slave.
  localparam logic [7:0] CTRL_OFF = 8'h00;
  localparam logic [7:0] INHIBIT_OFF = 8'h04;
  localparam logic [7:0] STEP_CMD_OFF = 8'h08;
  localparam logic [7:0] STEP_INDEX_OFF = 8'h0c;
  localparam logic [7:0] VALUE_OFF = 8'h10;
  localparam logic [7:0] STATUS_OFF = 8'h14;

  // Control register field positions.
  localparam int CTRL_DIR_DOWN_BIT = 0;
  localparam int CTRL_OPEN_BIT = 1;
  localparam int CTRL_INH_EN_BIT = 2;
  localparam int CTRL_SEQ_LSB = 4;
  localparam int CTRL_LVL_LSB = 8;

  // Status register field positions.
  localparam int STAT_LEVEL_BIT = 0;
  localparam int STAT_INHIBITED_BIT = 1;
  localparam int STAT_MANUAL_BIT = 2;
  localparam int STAT_BASE_LSB = 8;

  // Pattern selection codes.
  typedef enum logic [2:0] {
    ssq_seq_saturate = 3'h1,
    ssq_seq_gray = 3'h2,
    ssq_seq_fill_drain = 3'h3,
    ssq_seq_fill_clear = 3'h4,
    ssq_seq_one_hot = 3'h5
  } ssq_seq_t;

  // Level count limits and reset values.
  localparam logic [2:0] MIN_LEVELS = 3'h2;
  localparam logic [2:0] MAX_LEVELS = 3'h5;
  localparam logic [2:0] LEVELS_RESET = 3'h2;
  localparam ssq_seq_t SEQ_RESET = ssq_seq_saturate;
  localparam logic [7:0] STEP_INDEX_RESET = 8'h00;
  localparam logic [4:0] VALUE_RESET = 5'h00;

  // Object numbering per input.
  localparam logic [6:0] OBJ_FIRST = 7'h0a;
  localparam logic [6:0] OBJ_PER_INPUT = 7'h0a;
  localparam int SEND_STEP_BIT = 5;

endpackage

/* File: design/ssq_sync2.sv */
`timescale 1ns/1ps
module ssq_sync2 import ssq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);

  logic meta;

  // The first stage feeds only the second stage.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta <= 1'b0;
      q <= 1'b0;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

/* File: design/ssq_pattern.sv */
`timescale 1ns/1ps
module ssq_pattern import ssq_pkg::*; (
  input wire logic [7:0] idx,
  input wire logic [2:0] levels,
  input wire ssq_seq_t seq,
  output logic [4:0] pattern,
  output logic [7:0] last,
  output logic cyclic
);

  logic [5:0] fill_n;
  logic [5:0] fill_k;
  logic [7:0] drain_idx;
  logic [2:0] hot_pos;

  always_comb begin
    fill_n = 6'((7'd1 << levels) - 7'd1);
    drain_idx = 8'({levels, 1'b0}) - idx;
    hot_pos = 3'((idx - 8'd1) >> 1);
    fill_k = 6'h00;
    pattern = 5'h00;
    last = 8'({5'h00, levels});
    cyclic = 1'b1;
    unique case (seq)
      ssq_seq_saturate: begin
        cyclic = 1'b0;
        fill_k = 6'((7'd1 << idx[2:0]) - 7'd1);
        pattern = fill_k[4:0];
      end
      ssq_seq_gray: begin
        last = 8'(fill_n);
        pattern = 5'(idx ^ (idx >> 1));
      end
      ssq_seq_fill_drain: begin
        last = 8'({levels, 1'b0}) - 8'd1;
        if (idx <= 8'({5'h00, levels})) begin
          fill_k = 6'((7'd1 << idx[2:0]) - 7'd1);
        end else begin
          fill_k = 6'((7'd1 << drain_idx[2:0]) - 7'd1);
        end
        pattern = fill_k[4:0];
      end
      ssq_seq_fill_clear: begin
        fill_k = 6'((7'd1 << idx[2:0]) - 7'd1);
        pattern = fill_k[4:0];
      end
      ssq_seq_one_hot: begin
        last = 8'({levels, 1'b0}) - 8'd1;
        if (idx[0]) begin
          pattern = 5'(6'd1 << hot_pos);
        end
      end
      default: begin
        pattern = 5'h00;
      end
    endcase
  end

endmodule

/* File: design/ssq_top.sv */
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ssq_top import ssq_pkg::*; #(
  parameter logic [2:0] INPUT_NUM = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic contact_in,
  input wire logic manual_in,
  output logic [4:0] value_obj,
  output logic [7:0] step_obj,
  output logic [5:0] send_mask,
  output logic [6:0] obj_base,
  output logic input_inhibited
);

  logic dir_down;
  logic contact_open;
  logic inhibit_en;
  ssq_seq_t seq_sel;
  logic [2:0] level_count_setting;
  logic inhibit_obj;
  logic contact_sync;
  logic manual_sync;
  logic manual_prev;
  logic held_level;
  logic actuated_now;
  logic inhibited;
  logic actuation;
  logic manual_press;
  logic bus_fire;
  logic wr_fire;
  logic ctrl_wr;
  logic inhibit_wr;
  logic cmd_wr;
  logic index_wr;
  logic value_wr;
  logic step_up;
  logic step_down;
  logic [7:0] last;
  logic cyclic;
  logic [7:0] cur_idx;
  logic [7:0] next_step_obj;
  logic [4:0] next_pattern;
  logic [4:0] level_mask;
  logic [2:0] wr_levels;
  logic [31:0] next_prdata;
  logic addr_ok;

  ssq_sync2 u_contact_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(contact_in),
    .q(contact_sync)
  );

  ssq_sync2 u_manual_sync (
    .pclk(pclk),
    .presetn(presetn),
    .d(manual_in),
    .q(manual_sync)
  );

  // The pattern is looked up from the next index, so values and index move at one edge.
  ssq_pattern u_pattern (
    .idx(next_step_obj),
    .levels(level_count_setting),
    .seq(seq_sel),
    .pattern(next_pattern),
    .last(last),
    .cyclic(cyclic)
  );

  // Bus decode. Every access completes in its first access cycle, with no wait state.
  assign bus_fire = psel && penable && pready;
  assign wr_fire = bus_fire && pwrite;
  assign ctrl_wr = wr_fire && (paddr == CTRL_OFF);
  assign inhibit_wr = wr_fire && (paddr == INHIBIT_OFF);
  assign cmd_wr = wr_fire && (paddr == STEP_CMD_OFF);
  assign index_wr = wr_fire && (paddr == STEP_INDEX_OFF);
  assign value_wr = wr_fire && (paddr == VALUE_OFF);
  assign addr_ok = (paddr == CTRL_OFF) || (paddr == INHIBIT_OFF) ||
                   (paddr == STEP_CMD_OFF) || (paddr == STEP_INDEX_OFF) ||
                   (paddr == VALUE_OFF) || (paddr == STATUS_OFF);

  // Out-of-range level counts are pulled to the nearest legal value.
  always_comb begin
    wr_levels = pwdata[CTRL_LVL_LSB +: 3];
    if (wr_levels < MIN_LEVELS) begin
      wr_levels = MIN_LEVELS;
    end else if (wr_levels > MAX_LEVELS) begin
      wr_levels = MAX_LEVELS;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_down <= 1'b0;
      contact_open <= 1'b0;
      inhibit_en <= 1'b0;
      seq_sel <= SEQ_RESET;
      level_count_setting <= LEVELS_RESET;
    end else if (ctrl_wr) begin
      dir_down <= pwdata[CTRL_DIR_DOWN_BIT];
      contact_open <= pwdata[CTRL_OPEN_BIT];
      inhibit_en <= pwdata[CTRL_INH_EN_BIT];
      level_count_setting <= wr_levels;
      // An illegal sequence code keeps the old pattern; the other fields still update.
      if ((pwdata[CTRL_SEQ_LSB +: 3] >= 3'h1) && (pwdata[CTRL_SEQ_LSB +: 3] <= 3'h5)) begin
        seq_sel <= ssq_seq_t'(pwdata[CTRL_SEQ_LSB +: 3]);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_obj <= 1'b0;
    end else if (inhibit_wr) begin
      // Stored even while the object is disabled; enabling it later acts at once.
      inhibit_obj <= pwdata[0];
    end
  end

  // Input evaluation. The held level freezes while inhibited, so a level
  // that moved during the block is seen as a change right at release.
  assign inhibited = inhibit_en && inhibit_obj;
  assign actuated_now = contact_sync ^ contact_open;
  assign actuation = !inhibited && (actuated_now != held_level) && actuated_now;
  assign manual_press = manual_sync && !manual_prev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      held_level <= 1'b0;
    end else if (!inhibited) begin
      held_level <= actuated_now;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      manual_prev <= 1'b0;
    end else begin
      // Manual edges bypass the inhibit, so the local key keeps working.
      manual_prev <= manual_sync;
    end
  end

  // Step requests from the press, the manual key and the command object.
  // Opposite requests in one cycle cancel each other.
  assign step_up = (cmd_wr && pwdata[0]) ||
                   ((actuation || manual_press) && !dir_down);
  assign step_down = (cmd_wr && !pwdata[0]) ||
                     ((actuation || manual_press) && dir_down);
  assign cur_idx = (step_obj > last) ? last : step_obj;

  always_comb begin
    next_step_obj = cur_idx;
    if (index_wr) begin
      next_step_obj = (pwdata[7:0] > last) ? last : pwdata[7:0];
    end else if (step_up && !step_down) begin
      if (cur_idx >= last) begin
        next_step_obj = cyclic ? 8'h00 : last;
      end else begin
        next_step_obj = cur_idx + 8'd1;
      end
    end else if (step_down && !step_up) begin
      if (cur_idx == 8'h00) begin
        next_step_obj = cyclic ? last : 8'h00;
      end else begin
        next_step_obj = cur_idx - 8'd1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_obj <= STEP_INDEX_RESET;
    end else begin
      // Loaded every cycle, so an index above a shrunken limit is pulled in at once.
      step_obj <= next_step_obj;
    end
  end

  assign level_mask = 5'((6'd1 << level_count_setting) - 6'd1);

  // Value objects follow the index; a bus write overrides them quietly, unless the index moves in the same cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      value_obj <= VALUE_RESET;
    end else if (next_step_obj != step_obj) begin
      value_obj <= next_pattern & level_mask;
    end else if (value_wr) begin
      value_obj <= pwdata[4:0] & level_mask;
    end
  end

  // Send strobes for changed objects, one cycle wide.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      send_mask <= 6'h00;
    end else if (next_step_obj != step_obj) begin
      send_mask[SEND_STEP_BIT] <= 1'b1;
      // Only enabled objects are reported; hidden ones never send.
      send_mask[4:0] <= ((next_pattern & level_mask) ^ value_obj) & level_mask;
    end else begin
      send_mask <= 6'h00;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      obj_base <= OBJ_FIRST;
    end else begin
      // Constant per input, registered so that the port comes from a flip-flop.
      obj_base <= OBJ_FIRST + 7'(INPUT_NUM * OBJ_PER_INPUT);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_inhibited <= 1'b0;
    end else begin
      // The status pin shows the effective inhibit, not the raw object.
      input_inhibited <= inhibited;
    end
  end

  // Read data is captured in the setup cycle.
  always_comb begin
    next_prdata = 32'h0000_0000;
    unique case (paddr)
      CTRL_OFF: begin
        next_prdata[CTRL_DIR_DOWN_BIT] = dir_down;
        next_prdata[CTRL_OPEN_BIT] = contact_open;
        next_prdata[CTRL_INH_EN_BIT] = inhibit_en;
        next_prdata[CTRL_SEQ_LSB +: 3] = seq_sel;
        next_prdata[CTRL_LVL_LSB +: 3] = level_count_setting;
      end
      INHIBIT_OFF: begin
        next_prdata[0] = inhibit_obj;
      end
      STEP_INDEX_OFF: begin
        next_prdata[7:0] = step_obj;
      end
      VALUE_OFF: begin
        next_prdata[4:0] = value_obj;
      end
      STATUS_OFF: begin
        next_prdata[STAT_LEVEL_BIT] = actuated_now;
        next_prdata[STAT_INHIBITED_BIT] = inhibited;
        next_prdata[STAT_MANUAL_BIT] = manual_sync;
        next_prdata[STAT_BASE_LSB +: 7] = obj_base;
      end
      default: begin
        next_prdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      // The error flag stands only with pready, so it drops after the access cycle.
      pslverr <= psel && !penable && !addr_ok;
      if (psel && !penable) begin
        prdata <= pwrite ? 32'h0000_0000 : next_prdata;
      end
    end
  end

endmodule

/* File: test/ssq_bus_node.sv */
`timescale 1ns/1ps
// Listening node on the automation bus; it keeps the last step index telegram it heard.
module ssq_bus_node import ssq_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [5:0] send_mask,
  input wire logic [7:0] step_obj,
  output logic [7:0] heard
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heard <= 8'h00;
    end else if (send_mask[SEND_STEP_BIT]) begin
      heard <= step_obj;
    end
  end
endmodule

/* File: test/ssq_properties.sv */
`timescale 1ns/1ps
module ssq_checker import ssq_pkg::*; #(
  parameter logic [2:0] INPUT_NUM = 3'h0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic contact_in,
  input wire logic manual_in,
  input wire logic [4:0] value_obj,
  input wire logic [7:0] step_obj,
  input wire logic [5:0] send_mask,
  input wire logic [6:0] obj_base,
  input wire logic input_inhibited
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_index_write;
    psel && penable && pready && pwrite && paddr == STEP_INDEX_OFF;
  endsequence
  a_ready_after_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("access cycle without pready");
  a_ready_idle: assert property (!psel |=> !pready)
    else $error("pready without request");
  a_err_with_ready: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("pslverr outside access or with data");
  a_base_number: assert property (obj_base == 7'(OBJ_FIRST + OBJ_PER_INPUT * INPUT_NUM))
    else $error("object base number wrong");
  a_send_value_diff: assert property (|send_mask[4:0] |->
    send_mask[4:0] == (value_obj ^ $past(value_obj)))
    else $error("value send mask does not match change");
  a_step_bounded: assert property (step_obj <= 8'h1f)
    else $error("step index beyond longest pattern");
  a_step_sent: assert property ($changed(step_obj) |-> send_mask[SEND_STEP_BIT])
    else $error("step index changed without send");
  a_index_written: assert property (s_index_write |=> step_obj <= $past(pwdata[7:0]))
    else $error("step index write not clamped");
  a_err_one_cycle: assert property (pslverr |=> !pslverr)
    else $error("pslverr stands beyond the access cycle");
endmodule
bind ssq_top ssq_checker #(.INPUT_NUM(INPUT_NUM)) u_chk (.*);

/* File: test/ssq_top_test.sv */
`timescale 1ns/1ps
module ssq_top_test;
  import ssq_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, contact_in, manual_in, er;
  logic pready, pslverr, input_inhibited;
  logic [7:0] paddr, step_obj, heard;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] value_obj;
  logic [5:0] send_mask;
  logic [6:0] obj_base;
  int n_errors = 0;
  int checks = 0;
  ssq_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .contact_in, .manual_in, .value_obj, .step_obj, .send_mask,
    .obj_base, .input_inhibited);
  ssq_bus_node u_node (.pclk, .presetn, .send_mask, .step_obj, .heard);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d n_errors=%0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // The wait is bounded although the slave never inserts wait states.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 9) begin
      n_errors++;
      test_done();
    end
    #1;
  endtask
  // Pins pass a two-stage synchroniser, so a few edges are allowed to settle.
  task automatic pin(input logic [1:0] m);
    @(posedge pclk);
    if (m == 2'h1) manual_in <= ~manual_in;
    else if (m == 2'h0) contact_in <= ~contact_in;
    repeat (5) @(posedge pclk);
    #1;
  endtask
  task automatic obj(input logic [7:0] s, input logic [4:0] v);
    chk(32'({step_obj, value_obj}), 32'({s, v}));
  endtask
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    contact_in = 1'b0;
    manual_in = 1'b0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    #1;
    obj(8'h00, 5'h00);
    chk(32'(obj_base), 32'h0a);
    apb(1'b1, CTRL_OFF, 32'h340);
    for (int i = 1; i <= 4; i++) begin
      apb(1'b1, STEP_CMD_OFF, 32'h1);
      obj(8'(i % 4), 5'((1 << (i % 4)) - 1));
    end
    apb(1'b1, STEP_CMD_OFF, 32'h0);
    obj(8'h03, 5'h07);
    @(posedge pclk);
    #1;
    chk(32'(heard), 32'h03);
    apb(1'b1, STEP_INDEX_OFF, 32'h1);
    obj(8'h01, 5'h01);
    apb(1'b1, STEP_INDEX_OFF, 32'h9);
    obj(8'h03, 5'h07);
    $display("test fill_clear done");
    apb(1'b1, CTRL_OFF, 32'h350);
    apb(1'b1, STEP_INDEX_OFF, 32'h0);
    for (int i = 1; i <= 6; i++) begin
      apb(1'b1, STEP_CMD_OFF, 32'h1);
      obj(8'(i % 6), (i % 2) ? 5'(1 << (i / 2)) : 5'h00);
    end
    apb(1'b1, CTRL_OFF, 32'h210);
    apb(1'b1, STEP_INDEX_OFF, 32'h0);
    for (int i = 1; i <= 3; i++) begin
      apb(1'b1, STEP_CMD_OFF, 32'h1);
      obj((i > 1) ? 8'h02 : 8'h01, (i > 1) ? 5'h03 : 5'h01);
    end
    apb(1'b1, CTRL_OFF, 32'h330);
    apb(1'b1, STEP_INDEX_OFF, 32'h4);
    obj(8'h04, 5'h03);
    apb(1'b1, STEP_CMD_OFF, 32'h1);
    obj(8'h05, 5'h01);
    apb(1'b1, STEP_CMD_OFF, 32'h1);
    obj(8'h00, 5'h00);
    apb(1'b1, CTRL_OFF, 32'h220);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, STEP_INDEX_OFF, 32'(i));
      obj(8'(i), 5'(i ^ (i >> 1)));
    end
    $display("test patterns done");
    apb(1'b0, 8'h18, 32'h0);
    chk(32'(er), 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, CTRL_OFF, 32'h740);
    apb(1'b0, CTRL_OFF, 32'h0);
    chk(32'(rd[10:8]), 32'h5);
    apb(1'b1, CTRL_OFF, 32'h240);
    apb(1'b1, VALUE_OFF, 32'h1f);
    apb(1'b0, VALUE_OFF, 32'h0);
    chk(rd, 32'h03);
    $display("test registers done");
    apb(1'b1, CTRL_OFF, 32'h540);
    apb(1'b1, STEP_INDEX_OFF, 32'h0);
    pin(2'h0);
    obj(8'h01, 5'h01);
    pin(2'h0);
    apb(1'b1, CTRL_OFF, 32'h541);
    pin(2'h0);
    obj(8'h00, 5'h00);
    pin(2'h0);
    apb(1'b1, CTRL_OFF, 32'h544);
    apb(1'b1, INHIBIT_OFF, 32'h1);
    pin(2'h0);
    chk(32'({input_inhibited, step_obj}), 32'h100);
    pin(2'h1);
    obj(8'h01, 5'h01);
    chk(32'(heard), 32'h01);
    apb(1'b0, STATUS_OFF, 32'h0);
    chk(rd, 32'h0000_0a07);
    pin(2'h1);
    apb(1'b1, INHIBIT_OFF, 32'h0);
    pin(2'h2);
    chk(32'({input_inhibited, step_obj}), 32'h002);
    apb(1'b1, CTRL_OFF, 32'h546);
    pin(2'h0);
    obj(8'h03, 5'h07);
    $display("test inhibit done");
    test_done();
  end
endmodule
